//--- rtl/asq_pkg.sv
// Shared constants, types and helpers for the amplifier start-up and shutdown sequencer
package asq_pkg;

  // Register addresses seen over the control port
  localparam logic [7:0] REG_STATUS   = 8'h02;
  localparam logic [7:0] REG_SYSCTL   = 8'h05;
  localparam logic [7:0] REG_PWM_TIME = 8'h1A;
  localparam logic [7:0] REG_TRIM     = 8'h1B;

  // Command values and reset values
  localparam logic [7:0] SYSCTL_SHUTDOWN = 8'h40;
  localparam logic [7:0] SYSCTL_RUN      = 8'h00;
  localparam logic [7:0] SYSCTL_RST      = 8'h40;
  localparam logic [7:0] TRIM_CMD        = 8'h00;
  localparam logic [7:0] TRIM_RST        = 8'hFF;
  localparam logic [7:0] PWM_TIME_RST    = 8'h00;

  // PWM start/stop timing field layout: code n means (n + 1) steps
  localparam int CODE_W    = 4;
  localparam int START_LSB = 0;
  localparam int STOP_LSB  = 4;

  // Status register bit positions
  localparam int ST_SHUT  = 0;
  localparam int ST_PWM   = 1;
  localparam int ST_RAMP  = 2;
  localparam int ST_GUARD = 3;
  localparam int ST_TRIM  = 4;
  localparam int ST_FIRST = 5;

  // Timing
  localparam int CLK_HZ      = 25_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int GUARD_MS    = 240;
  localparam int PWM_STEP_MS = 10;
  localparam int WAIT_W      = 12;
  localparam int MS_CNT_W    = 16;

  // Control port default slave address (arbitrary)
  localparam logic [6:0] DEV_ADDR_DFLT = 7'h2A;

  // PWM stage state
  typedef enum logic [1:0] {
    ASQ_PWM_OFF   = 2'b00,
    ASQ_PWM_START = 2'b01,
    ASQ_PWM_RUN   = 2'b10,
    ASQ_PWM_STOP  = 2'b11
  } asq_pwm_t;

  // Control port byte-level state
  typedef enum logic [2:0] {
    ASQ_I2C_IDLE  = 3'b000,
    ASQ_I2C_ADDR  = 3'b001,
    ASQ_I2C_SUB   = 3'b010,
    ASQ_I2C_WDATA = 3'b011,
    ASQ_I2C_ACK   = 3'b100,
    ASQ_I2C_RDATA = 3'b101,
    ASQ_I2C_RACK  = 3'b110
  } asq_i2c_t;

  // Pin filter: a new level counts once the second and third stages agree
  function automatic logic asq_filt(input logic s2, input logic s3, input logic old);
    asq_filt = (s2 == s3) ? s3 : old;
  endfunction

endpackage

//--- rtl/asq_i2c_slave.sv
// Control port slave: byte writes with auto-increment and register reads
`timescale 1ns/1ps
module asq_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = asq_pkg::DEV_ADDR_DFLT
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe,
  output logic            wr_stb,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);

  logic [2:0]      scl_sync_reg;
  logic [2:0]      sda_sync_reg;
  logic            scl_f_reg;
  logic            sda_f_reg;
  logic            scl_d_reg;
  logic            sda_d_reg;
  asq_pkg::asq_i2c_t state_reg;
  asq_pkg::asq_i2c_t after_ack_reg;
  logic [3:0]      cnt_reg;
  logic [7:0]      sh_reg;
  logic [7:0]      ptr_reg;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_ev;
  logic            stop_ev;

  //////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers and agreement filter
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg    <= 1'b1;
      sda_f_reg    <= 1'b1;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      scl_f_reg    <= asq_pkg::asq_filt(scl_sync_reg[1], scl_sync_reg[2], scl_f_reg);
      sda_f_reg    <= asq_pkg::asq_filt(sda_sync_reg[1], sda_sync_reg[2], sda_f_reg);
      scl_d_reg    <= scl_f_reg;
      sda_d_reg    <= sda_f_reg;
    end
  end

  // Bus events
  assign scl_rise = scl_f_reg & ~scl_d_reg;
  assign scl_fall = ~scl_f_reg & scl_d_reg;
  assign start_ev = scl_f_reg & scl_d_reg & sda_d_reg & ~sda_f_reg;
  assign stop_ev  = scl_f_reg & scl_d_reg & ~sda_d_reg & sda_f_reg;
  assign rd_addr  = ptr_reg;

  //////////////////////////////////////////////////////////////////////////
  // Byte engine: sample on SCL rise, drive on SCL fall
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg     <= asq_pkg::ASQ_I2C_IDLE;
      after_ack_reg <= asq_pkg::ASQ_I2C_IDLE;
      cnt_reg       <= 4'h0;
      sh_reg        <= 8'h00;
      ptr_reg       <= 8'h00;
      sda_oe        <= 1'b0;
      wr_stb        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_ev) begin
        state_reg <= asq_pkg::ASQ_I2C_ADDR;
        cnt_reg   <= 4'h0;
        sda_oe    <= 1'b0;
      end else if (stop_ev) begin
        state_reg <= asq_pkg::ASQ_I2C_IDLE;
        sda_oe    <= 1'b0;
      end else if (scl_rise) begin
        unique case (state_reg)
          asq_pkg::ASQ_I2C_ADDR, asq_pkg::ASQ_I2C_SUB, asq_pkg::ASQ_I2C_WDATA: begin
            if (cnt_reg != 4'h8) begin
              sh_reg  <= {sh_reg[6:0], sda_f_reg};
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          asq_pkg::ASQ_I2C_RACK: begin
            // Master NACK ends the read; ACK fetches the next byte
            if (sda_f_reg) begin
              state_reg <= asq_pkg::ASQ_I2C_IDLE;
            end else begin
              state_reg     <= asq_pkg::ASQ_I2C_ACK;
              after_ack_reg <= asq_pkg::ASQ_I2C_RDATA;
            end
          end
          asq_pkg::ASQ_I2C_IDLE, asq_pkg::ASQ_I2C_ACK, asq_pkg::ASQ_I2C_RDATA: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (state_reg)
          asq_pkg::ASQ_I2C_ADDR: begin
            if (cnt_reg == 4'h8) begin
              if (sh_reg[7:1] == DEV_ADDR) begin
                sda_oe        <= 1'b1;
                state_reg     <= asq_pkg::ASQ_I2C_ACK;
                after_ack_reg <= sh_reg[0] ? asq_pkg::ASQ_I2C_RDATA : asq_pkg::ASQ_I2C_SUB;
              end else begin
                state_reg <= asq_pkg::ASQ_I2C_IDLE;
              end
            end
          end
          asq_pkg::ASQ_I2C_SUB: begin
            if (cnt_reg == 4'h8) begin
              ptr_reg       <= sh_reg;
              sda_oe        <= 1'b1;
              state_reg     <= asq_pkg::ASQ_I2C_ACK;
              after_ack_reg <= asq_pkg::ASQ_I2C_WDATA;
            end
          end
          asq_pkg::ASQ_I2C_WDATA: begin
            if (cnt_reg == 4'h8) begin
              wr_stb        <= 1'b1;
              wr_addr       <= ptr_reg;
              wr_data       <= sh_reg;
              ptr_reg       <= ptr_reg + 8'h01;
              sda_oe        <= 1'b1;
              state_reg     <= asq_pkg::ASQ_I2C_ACK;
              after_ack_reg <= asq_pkg::ASQ_I2C_WDATA;
            end
          end
          asq_pkg::ASQ_I2C_ACK: begin
            state_reg <= after_ack_reg;
            if (after_ack_reg == asq_pkg::ASQ_I2C_RDATA) begin
              // Status and registers go back to the host
              sda_oe  <= ~rd_data[7];
              sh_reg  <= {rd_data[6:0], 1'b0};
              cnt_reg <= 4'h1;
              ptr_reg <= ptr_reg + 8'h01;
            end else begin
              sda_oe  <= 1'b0;
              cnt_reg <= 4'h0;
            end
          end
          asq_pkg::ASQ_I2C_RDATA: begin
            if (cnt_reg == 4'h8) begin
              sda_oe    <= 1'b0;
              state_reg <= asq_pkg::ASQ_I2C_RACK;
            end else begin
              sda_oe  <= ~sh_reg[7];
              sh_reg  <= {sh_reg[6:0], 1'b0};
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
          asq_pkg::ASQ_I2C_IDLE, asq_pkg::ASQ_I2C_RACK: begin
          end
        endcase
      end
    end
  end

endmodule // asq_i2c_slave

//--- rtl/asq_top.sv
// Amplifier start-up, trim guard and shutdown sequencing behind the control port
`timescale 1ns/1ps
module asq_top #(
  parameter int         CYC_PER_MS = asq_pkg::CLK_HZ / asq_pkg::MS_PER_S,
  parameter logic [6:0] DEV_ADDR   = asq_pkg::DEV_ADDR_DFLT
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic reset_pin_n_i,
  input  wire logic powerdown_pin_n_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe,
  output logic      pwm_enable,
  output logic      pwm_ramping,
  output logic      shutdown_active,
  output logic      exit_guard_active
);

  logic [2:0]                  rstp_sync_reg;
  logic [2:0]                  pdn_sync_reg;
  logic                        rstp_n_reg;
  logic                        pdn_n_reg;
  logic [asq_pkg::MS_CNT_W-1:0] ms_cnt_reg;
  logic                        ms_tick;
  logic                        wr_stb;
  logic [7:0]                  wr_addr;
  logic [7:0]                  wr_data;
  logic [7:0]                  rd_addr;
  logic [7:0]                  rd_data;
  logic                        slv_sda_oe;
  logic [7:0]                  sysctl_reg;
  logic [7:0]                  pwm_time_reg;
  logic [7:0]                  trim_reg;
  logic                        trimmed_reg;
  logic                        first_pend_reg;
  logic [asq_pkg::WAIT_W-1:0]  guard_cnt_reg;
  logic [asq_pkg::WAIT_W-1:0]  wait_cnt_reg;
  asq_pkg::asq_pwm_t           pwm_state_reg;
  logic [7:0]                  mem [0:255];
  logic [7:0]                  status;
  logic                        trim_wr;
  logic                        sysctl_wr;
  logic                        exit_ignored;

  // Ramp length in ms from a timing code: (code + 1) steps
  function automatic logic [asq_pkg::WAIT_W-1:0] ramp_ms(input logic [asq_pkg::CODE_W-1:0] code);
    ramp_ms = asq_pkg::WAIT_W'((code + 1) * asq_pkg::PWM_STEP_MS);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Reset and powerdown pin synchronisers
  always_ff @(posedge clk) begin
    if (srst) begin
      rstp_sync_reg <= 3'h0;
      pdn_sync_reg  <= 3'h0;
      rstp_n_reg    <= 1'b0;
      pdn_n_reg     <= 1'b0;
    end else begin
      rstp_sync_reg <= {rstp_sync_reg[1:0], reset_pin_n_i};
      pdn_sync_reg  <= {pdn_sync_reg[1:0], powerdown_pin_n_i};
      rstp_n_reg    <= asq_pkg::asq_filt(rstp_sync_reg[1], rstp_sync_reg[2], rstp_n_reg);
      pdn_n_reg     <= asq_pkg::asq_filt(pdn_sync_reg[1], pdn_sync_reg[2], pdn_n_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Millisecond enable
  always_ff @(posedge clk) begin
    if (srst || ms_tick) begin
      ms_cnt_reg <= '0;
    end else begin
      ms_cnt_reg <= ms_cnt_reg + 1'b1;
    end
  end
  assign ms_tick = (ms_cnt_reg == asq_pkg::MS_CNT_W'(CYC_PER_MS - 1));

  //////////////////////////////////////////////////////////////////////////
  // Control port
  asq_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .clk     (clk),
    .srst    (srst),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .sda_oe  (slv_sda_oe),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // Open-drain data line only ever pulls low
  always_ff @(posedge clk) begin
    if (srst) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end
  assign sda_oe = slv_sda_oe;

  // Write decodes
  assign trim_wr      = wr_stb && (wr_addr == asq_pkg::REG_TRIM) && (wr_data == asq_pkg::TRIM_CMD);
  assign sysctl_wr    = wr_stb && (wr_addr == asq_pkg::REG_SYSCTL);
  assign exit_ignored = (guard_cnt_reg != '0) && (wr_data == asq_pkg::SYSCTL_RUN);

  //////////////////////////////////////////////////////////////////////////
  // Control registers, cleared by power-up or the reset pin
  always_ff @(posedge clk) begin
    if (srst || !rstp_n_reg) begin
      sysctl_reg   <= asq_pkg::SYSCTL_RST;
      pwm_time_reg <= asq_pkg::PWM_TIME_RST;
      trim_reg     <= asq_pkg::TRIM_RST;
      trimmed_reg  <= 1'b0;
    end else if (wr_stb) begin
      if (sysctl_wr && !exit_ignored) begin
        sysctl_reg <= wr_data;
      end
      if (wr_addr == asq_pkg::REG_PWM_TIME) begin
        pwm_time_reg <= wr_data;
      end
      if (wr_addr == asq_pkg::REG_TRIM) begin
        trim_reg <= wr_data;
      end
      if (trim_wr) begin
        trimmed_reg <= 1'b1;
      end
    end
  end

  // General register storage for processor coefficients, volume and mute
  always_ff @(posedge clk) begin
    if (wr_stb) begin
      mem[wr_addr] <= wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Exit guard after the first trim following power-up only
  always_ff @(posedge clk) begin
    if (srst) begin
      first_pend_reg <= 1'b1;
      guard_cnt_reg  <= '0;
    end else if (trim_wr && first_pend_reg) begin
      first_pend_reg <= 1'b0;
      guard_cnt_reg  <= asq_pkg::WAIT_W'(asq_pkg::GUARD_MS);
    end else if (ms_tick && guard_cnt_reg != '0) begin
      guard_cnt_reg <= guard_cnt_reg - 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // PWM stage sequencing
  always_ff @(posedge clk) begin
    if (srst || !rstp_n_reg || !pdn_n_reg) begin
      pwm_state_reg <= asq_pkg::ASQ_PWM_OFF;
      wait_cnt_reg  <= '0;
    end else begin
      unique case (pwm_state_reg)
        asq_pkg::ASQ_PWM_OFF: begin
          if (sysctl_reg == asq_pkg::SYSCTL_RUN) begin
            pwm_state_reg <= asq_pkg::ASQ_PWM_START;
            wait_cnt_reg  <= ramp_ms(pwm_time_reg[asq_pkg::START_LSB +: asq_pkg::CODE_W]);
          end
        end
        asq_pkg::ASQ_PWM_START: begin
          if (sysctl_reg == asq_pkg::SYSCTL_SHUTDOWN) begin
            pwm_state_reg <= asq_pkg::ASQ_PWM_STOP;
            wait_cnt_reg  <= ramp_ms(pwm_time_reg[asq_pkg::STOP_LSB +: asq_pkg::CODE_W]);
          end else if (wait_cnt_reg == '0) begin
            pwm_state_reg <= asq_pkg::ASQ_PWM_RUN;
          end else if (ms_tick) begin
            wait_cnt_reg <= wait_cnt_reg - 1'b1;
          end
        end
        asq_pkg::ASQ_PWM_RUN: begin
          if (sysctl_reg == asq_pkg::SYSCTL_SHUTDOWN) begin
            pwm_state_reg <= asq_pkg::ASQ_PWM_STOP;
            wait_cnt_reg  <= ramp_ms(pwm_time_reg[asq_pkg::STOP_LSB +: asq_pkg::CODE_W]);
          end
        end
        asq_pkg::ASQ_PWM_STOP: begin
          if (wait_cnt_reg == '0) begin
            pwm_state_reg <= asq_pkg::ASQ_PWM_OFF;
          end else if (ms_tick) begin
            wait_cnt_reg <= wait_cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Readback: status is live, other addresses return stored bytes
  always_comb begin
    status                    = 8'h00;
    status[asq_pkg::ST_SHUT]  = (pwm_state_reg == asq_pkg::ASQ_PWM_OFF);
    status[asq_pkg::ST_PWM]   = (pwm_state_reg != asq_pkg::ASQ_PWM_OFF);
    status[asq_pkg::ST_RAMP]  = (pwm_state_reg == asq_pkg::ASQ_PWM_START) ||
                                (pwm_state_reg == asq_pkg::ASQ_PWM_STOP);
    status[asq_pkg::ST_GUARD] = (guard_cnt_reg != '0);
    status[asq_pkg::ST_TRIM]  = trimmed_reg;
    status[asq_pkg::ST_FIRST] = first_pend_reg;
    unique case (rd_addr)
      asq_pkg::REG_STATUS:   rd_data = status;
      asq_pkg::REG_SYSCTL:   rd_data = sysctl_reg;
      asq_pkg::REG_PWM_TIME: rd_data = pwm_time_reg;
      asq_pkg::REG_TRIM:     rd_data = trim_reg;
      default:               rd_data = mem[rd_addr];
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_enable        <= 1'b0;
      pwm_ramping       <= 1'b0;
      shutdown_active   <= 1'b1;
      exit_guard_active <= 1'b0;
    end else begin
      pwm_enable        <= status[asq_pkg::ST_PWM];
      pwm_ramping       <= status[asq_pkg::ST_RAMP];
      shutdown_active   <= status[asq_pkg::ST_SHUT];
      exit_guard_active <= status[asq_pkg::ST_GUARD];
    end
  end

endmodule // asq_top

//--- testbench/asq_top_props.sv
// Port-level checker for the sequencer, bound into the top module
`timescale 1ns/1ps
module asq_top_props #(
  parameter int CYC_PER_MS = 10
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic reset_pin_n_i,
  input wire logic powerdown_pin_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic pwm_enable,
  input wire logic pwm_ramping,
  input wire logic shutdown_active,
  input wire logic exit_guard_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  // Cycle counters: guard window length and ramp length
  logic [15:0] guard_cnt_reg;
  logic [15:0] ramp_cnt_reg;
  always_ff @(posedge clk) guard_cnt_reg <= (srst || !exit_guard_active) ? 16'h0000 : guard_cnt_reg + 16'h0001;
  always_ff @(posedge clk) ramp_cnt_reg <= (srst || !pwm_ramping) ? 16'h0000 : ramp_cnt_reg + 16'h0001;
  // Pins held low long enough to pass the filters
  sequence s_pdn_low;
    !powerdown_pin_n_i [*8];
  endsequence
  sequence s_rst_low;
    !reset_pin_n_i [*8];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // Port relations
  a_reset_idle_out: assert property ($fell(srst) |-> shutdown_active && !pwm_enable && !exit_guard_active && !sda_oe)
    else $error("outputs not idle after reset");
  a_shut_vs_pwm: assert property (shutdown_active == !pwm_enable)
    else $error("shutdown flag disagrees with pwm enable");
  a_ramp_in_pwm: assert property (pwm_ramping |-> pwm_enable)
    else $error("ramp flagged with pwm off");
  a_guard_no_start: assert property ($rose(pwm_enable) |-> !exit_guard_active)
    else $error("pwm started inside guard window");
  a_guard_window_len: assert property ($fell(exit_guard_active) |->
    guard_cnt_reg >= (asq_pkg::GUARD_MS - 1) * CYC_PER_MS && guard_cnt_reg <= (asq_pkg::GUARD_MS + 1) * CYC_PER_MS)
    else $error("guard window length wrong");
  a_ramp_max_len: assert property (ramp_cnt_reg <= (16 * asq_pkg::PWM_STEP_MS + 1) * CYC_PER_MS)
    else $error("ramp longer than largest code");
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("sda drive changed while scl high");
  a_sda_pull_low: assert property (sda_oe |-> !sda_o)
    else $error("sda driven high");
  a_pdn_stops_pwm: assert property (s_pdn_low |-> !pwm_enable)
    else $error("pwm running with powerdown low");
  a_rst_pin_off: assert property (s_rst_low |-> shutdown_active)
    else $error("not shut down with reset pin low");
endmodule // asq_top_props

bind asq_top asq_top_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (
  .clk(clk), .srst(srst), .reset_pin_n_i(reset_pin_n_i), .powerdown_pin_n_i(powerdown_pin_n_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .pwm_enable(pwm_enable),
  .pwm_ramping(pwm_ramping), .shutdown_active(shutdown_active), .exit_guard_active(exit_guard_active)
);

//--- testbench/asq_host_model.sv
// Host controller model: control port master and pin sequencing
`timescale 1ns/1ps
module asq_host_model #(
  parameter int         CYC_PER_MS = 10,
  parameter logic [6:0] DEV_ADDR   = asq_pkg::DEV_ADDR_DFLT
) (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull,
  output logic      rst_n,
  output logic      pdn_n
);
  // All inputs low while the logic supply ramps
  initial begin
    scl = 1'b0;
    sda_pull = 1'b1;
    rst_n = 1'b0;
    pdn_n = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Bit-level helpers, every change just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic smp);
    sda_pull = ~b;
    tick(10);
    scl = 1'b1;
    tick(5);
    smp = sda_line;
    tick(5);
    scl = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] b, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
      rx[i] = s;
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic start_c();
    sda_pull = 1'b0;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_pull = 1'b1;
    tick(10);
    scl = 1'b0;
  endtask
  task automatic stop_c();
    sda_pull = 1'b1;
    tick(10);
    scl = 1'b1;
    tick(10);
    sda_pull = 1'b0;
    tick(10);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Register write and read transfers
  task automatic wr(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] d, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start_c();
    byte_io({dev, 1'b0}, rx, a0);
    byte_io(sub, rx, a1);
    byte_io(d, rx, a2);
    stop_c();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] sub, output logic [7:0] d);
    logic [7:0] rx;
    logic a;
    start_c();
    byte_io({DEV_ADDR, 1'b0}, rx, a);
    byte_io(sub, rx, a);
    start_c();
    byte_io({DEV_ADDR, 1'b1}, rx, a);
    byte_io(8'hFF, d, a);
    stop_c();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Sequencing steps; a missing acknowledge skips the wait and returns at once
  task automatic power_up();
    scl = 1'b1;
    sda_pull = 1'b0;
    pdn_n = 1'b1;
    tick(CYC_PER_MS);
    rst_n = 1'b1;
    tick(14 * CYC_PER_MS);
  endtask
  task automatic pin_reset();
    rst_n = 1'b0;
    tick(CYC_PER_MS);
    rst_n = 1'b1;
    tick(14 * CYC_PER_MS);
  endtask
  task automatic trim(output logic ok);
    wr(DEV_ADDR, 8'h1B, 8'h00, ok);
    if (ok) tick(50 * CYC_PER_MS);
  endtask
  task automatic guard_wait(input int code);
    tick(240 * CYC_PER_MS + 13 * (code + 1) * asq_pkg::PWM_STEP_MS * CYC_PER_MS / 10);
  endtask
  task automatic enter_sd(input int code, output logic ok);
    wr(DEV_ADDR, 8'h05, 8'h40, ok);
    if (ok) tick(CYC_PER_MS + 13 * (code + 1) * asq_pkg::PWM_STEP_MS * CYC_PER_MS / 10);
  endtask
  task automatic exit_sd(input int code, output logic ok);
    wr(DEV_ADDR, 8'h05, 8'h00, ok);
    if (ok) tick(CYC_PER_MS + 13 * (code + 1) * asq_pkg::PWM_STEP_MS * CYC_PER_MS / 10);
  endtask
  task automatic power_down();
    pdn_n = 1'b0;
    tick(2 * CYC_PER_MS);
    rst_n = 1'b0;
    tick(1);
    scl = 1'b0;
    sda_pull = 1'b1;
  endtask
endmodule // asq_host_model

//--- testbench/asq_tb_top.sv
// Self-checking bench for the start-up and shutdown sequencer
`timescale 1ns/1ps
module asq_tb_top;
  localparam int CYC = 10;
  localparam int STP = asq_pkg::PWM_STEP_MS;
  typedef struct { logic [7:0] sub; logic [7:0] data; logic [7:0] exp; } asq_row_t;
  logic       clk, srst, scl, h_pull, rst_n, pdn_n;
  logic       sda_o, sda_oe, pwm_en, ramping, shut, guard;
  logic [7:0] rd;
  logic       ok;
  int         failures = 0;
  int         cmp_count = 0;
  int         rcnt = 0;
  int         last_ramp = 0;
  wire        sda_line = ~(h_pull | (sda_oe & ~sda_o));
  asq_row_t   rows [4] = '{'{8'h1A, 8'h21, 8'h21}, '{8'h10, 8'hA5, 8'hA5}, '{8'h11, 8'h3C, 8'h3C},
                          '{8'h05, 8'h40, 8'h40}};
  ////////////////////////////////////////////////////////////////////////////////
  // Design and host
  asq_top #(.CYC_PER_MS(CYC)) DUT (.clk(clk), .srst(srst), .reset_pin_n_i(rst_n), .powerdown_pin_n_i(pdn_n),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .pwm_enable(pwm_en),
    .pwm_ramping(ramping), .shutdown_active(shut), .exit_guard_active(guard));
  asq_host_model #(.CYC_PER_MS(CYC)) host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(h_pull),
    .rst_n(rst_n), .pdn_n(pdn_n));
  // Clock, and a ramp length monitor
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ramping === 1'b1) rcnt++;
    else if (rcnt != 0) begin
      last_ramp = rcnt;
      rcnt = 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare tasks and verdict
  task automatic check_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check_ramp(input string nm, input int code);
    cmp_count++;
    if (last_ramp < ((code + 1) * STP - 1) * CYC || last_ramp > ((code + 1) * STP + 1) * CYC) begin
      failures++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, (code + 1) * STP * CYC, last_ramp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    srst = 1'b1;
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    host.power_up();
    check_bit("shut_rst", 1'b1, shut);
    check_bit("guard_rst", 1'b0, guard);
    host.rd(8'h05, rd);
    check_byte("sysctl_rst", 8'h40, rd);
    host.rd(8'h1A, rd);
    check_byte("pwmtime_rst", 8'h00, rd);
    host.rd(8'h1B, rd);
    check_byte("trim_rst", 8'hFF, rd);
    foreach (rows[i]) begin
      host.wr(asq_pkg::DEV_ADDR_DFLT, rows[i].sub, rows[i].data, ok);
      check_bit("row_ack", 1'b1, ok);
      host.rd(rows[i].sub, rd);
      check_byte("row_data", rows[i].exp, rd);
    end
    host.wr(7'h2B, 8'h10, 8'h00, ok);
    check_bit("wrong_addr_ack", 1'b0, ok);
    // First trim opens the guard; an early exit is dropped
    host.trim(ok);
    check_bit("guard_on", 1'b1, guard);
    host.rd(8'h02, rd);
    check_bit("status_guard", 1'b1, rd[asq_pkg::ST_GUARD]);
    host.wr(asq_pkg::DEV_ADDR_DFLT, 8'h05, 8'h00, ok);
    repeat (200) @(posedge clk);
    check_bit("early_exit_pwm", 1'b0, pwm_en);
    host.rd(8'h05, rd);
    check_byte("early_exit_reg", 8'h40, rd);
    host.guard_wait(1);
    check_bit("guard_off", 1'b0, guard);
    // Start and stop ramps follow the timing codes
    host.exit_sd(1, ok);
    check_ramp("start_ramp", 1);
    check_bit("run_pwm", 1'b1, pwm_en);
    host.enter_sd(2, ok);
    check_ramp("stop_ramp", 2);
    check_bit("sd_shut", 1'b1, shut);
    // Reconfigure in shutdown, later trim leaves the guard closed
    host.wr(asq_pkg::DEV_ADDR_DFLT, 8'h1A, 8'h00, ok);
    host.trim(ok);
    check_bit("retrim_guard", 1'b0, guard);
    host.exit_sd(0, ok);
    check_ramp("short_ramp", 0);
    // Reset pin: PWM off, defaults back, no new guard
    host.pin_reset();
    check_bit("pin_rst_shut", 1'b1, shut);
    host.rd(8'h05, rd);
    check_byte("pin_rst_reg", 8'h40, rd);
    host.trim(ok);
    check_bit("pin_rst_guard", 1'b0, guard);
    host.exit_sd(0, ok);
    check_bit("pin_rst_run", 1'b1, pwm_en);
    // Sudden power loss, then a fresh power-up re-arms the guard
    host.power_down();
    check_bit("pdn_pwm", 1'b0, pwm_en);
    check_bit("pdn_shut", 1'b1, shut);
    srst = 1'b1;
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    host.power_up();
    host.trim(ok);
    check_bit("second_guard", 1'b1, guard);
    final_report();
  end
endmodule // asq_tb_top
